// ---- rtl/sar_adc_ctrl.sv ----
module sar_adc_ctrl #(
  parameter int DIVIDE = adc_pkg::PRESCALE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // trigger sources
  input wire logic [adc_pkg::TRIG_N-1:0] trigger_in,
  // converter core
  input wire logic [adc_pkg::RES_W-1:0] core_result,
  output logic core_enable,
  output logic core_clk_tick,
  output logic core_start,
  output logic [1:0] reference_select,
  output logic [3:0] mux_positive,
  output logic [3:0] mux_negative,
  output logic amp_enable,
  output logic [1:0] amp_gain,
  // completion
  output logic conversion_irq
);
  typedef struct packed {
    logic enable;
    logic auto_trig;
    logic flag;
    logic irq_en;
    logic [adc_pkg::TSEL_W-1:0] tsel;
    logic [5:0] chan;
    logic [1:0] refsel;
    logic ladj;
    logic [1:0] gain;
    adc_pkg::conv_state_e state;
    logic [4:0] cnt;
    logic first_done;
    logic [adc_pkg::RES_W-1:0] result;
    logic locked;
    logic [5:0] act_chan;
    logic [1:0] act_ref;
    logic [1:0] act_gain;
    logic core_start;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dph_addr;
    logic hreadyout;
    logic [31:0] hrdata;
  } ctrl_s;
  ctrl_s s, next_s;
  logic tick;
  logic rise;
  logic trig_start;
  logic accept;
  logic free_run;
  logic done;
  logic [4:0] conv_len;
  // ---------------------------------------------
  // prescaler and trigger front end
  // ---------------------------------------------
  conv_prescaler #(
    .DIVIDE(DIVIDE)
  ) u_presc (
    .clk(clk),
    .rstn(rstn),
    .enable(s.enable),
    .restart(trig_start),
    .tick(tick)
  );
  trigger_edge #(
    .N(adc_pkg::TRIG_N),
    .SEL_W(adc_pkg::TSEL_W)
  ) u_trig (
    .clk(clk),
    .rstn(rstn),
    .sources(trigger_in),
    .select(s.tsel),
    .rise(rise)
  );
  assign accept = hsel & hready & htrans[adc_pkg::HTRANS_ACTIVE];
  assign free_run = s.auto_trig && (s.tsel == adc_pkg::TSEL_FREE);
  // edges only count while idle and not in free running
  assign trig_start = s.enable && s.auto_trig && !free_run && rise
    && (s.state == adc_pkg::ST_IDLE);
  assign conv_len = s.first_done ? adc_pkg::NORM_CONV : adc_pkg::FIRST_CONV;
  assign done = (s.state == adc_pkg::ST_CONV) && tick
    && (s.cnt == conv_len - 5'h01);
  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic sw_start;
    logic clr_flag;
    sw_start = 1'b0;
    clr_flag = 1'b0;
    next_s = s;
    next_s.core_start = 1'b0;
    // bus write data phase
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      unique case (s.dph_addr)
        adc_pkg::OFF_CTRL_A: begin
          next_s.enable = hwdata[adc_pkg::CA_ENABLE];
          next_s.auto_trig = hwdata[adc_pkg::CA_AUTO];
          next_s.irq_en = hwdata[adc_pkg::CA_IRQ_EN];
          clr_flag = hwdata[adc_pkg::CA_FLAG];
          sw_start = hwdata[adc_pkg::CA_START] && hwdata[adc_pkg::CA_ENABLE];
        end
        adc_pkg::OFF_CTRL_B: begin
          next_s.tsel = hwdata[adc_pkg::TSEL_W-1:0];
        end
        adc_pkg::OFF_CHAN_REF: begin
          next_s.chan = hwdata[adc_pkg::CR_CHAN_LSB +: 6];
          next_s.refsel = hwdata[adc_pkg::CR_REF_LSB +: 2];
          next_s.ladj = hwdata[adc_pkg::CR_LADJ];
          next_s.gain = hwdata[adc_pkg::CR_GAIN_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
    // bus read, one wait state
    if (s.rd_pend) begin
      next_s.rd_pend = 1'b0;
      next_s.hreadyout = 1'b1;
      next_s.hrdata = '0;
      unique case (s.dph_addr)
        adc_pkg::OFF_CTRL_A: begin
          next_s.hrdata[adc_pkg::CA_ENABLE] = s.enable;
          next_s.hrdata[adc_pkg::CA_START] = s.state != adc_pkg::ST_IDLE;
          next_s.hrdata[adc_pkg::CA_AUTO] = s.auto_trig;
          next_s.hrdata[adc_pkg::CA_FLAG] = s.flag;
          next_s.hrdata[adc_pkg::CA_IRQ_EN] = s.irq_en;
        end
        adc_pkg::OFF_CTRL_B: begin
          next_s.hrdata[adc_pkg::TSEL_W-1:0] = s.tsel;
        end
        adc_pkg::OFF_CHAN_REF: begin
          next_s.hrdata[adc_pkg::CR_CHAN_LSB +: 6] = s.chan;
          next_s.hrdata[adc_pkg::CR_REF_LSB +: 2] = s.refsel;
          next_s.hrdata[adc_pkg::CR_LADJ] = s.ladj;
          next_s.hrdata[adc_pkg::CR_GAIN_LSB +: 2] = s.gain;
        end
        adc_pkg::OFF_RES_LOW: begin
          next_s.hrdata[7:0] = s.ladj ? {s.result[1:0], 6'h00}
            : s.result[7:0];
          next_s.locked = 1'b1;
        end
        adc_pkg::OFF_RES_HIGH: begin
          next_s.hrdata[7:0] = s.ladj ? s.result[9:2]
            : {6'h00, s.result[9:8]};
          next_s.locked = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // new address phase
    if (accept) begin
      next_s.dph_addr = haddr[7:0];
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
      end else begin
        next_s.rd_pend = 1'b1;
        next_s.hreadyout = 1'b0;
      end
    end
    // conversion sequencing
    unique case (s.state)
      adc_pkg::ST_IDLE: begin
        if (sw_start || trig_start) begin
          next_s.state = adc_pkg::ST_WAIT;
        end
      end
      adc_pkg::ST_WAIT: begin
        if (tick) begin
          next_s.state = adc_pkg::ST_CONV;
          next_s.cnt = '0;
          next_s.core_start = 1'b1;
        end
      end
      adc_pkg::ST_CONV: begin
        if (tick) begin
          next_s.cnt = s.cnt + 5'h01;
        end
        if (done) begin
          if (!s.locked) begin
            next_s.result = core_result;
          end // else discarded
          next_s.first_done = 1'b1;
          next_s.cnt = '0;
          if (free_run) begin
            next_s.core_start = 1'b1;
          end else begin
            next_s.state = adc_pkg::ST_IDLE;
          end
        end
      end
    endcase
    // settings follow software only while enabled and either not converting or in the cycle a conversion completes
    if (s.enable && (s.state != adc_pkg::ST_CONV || done)) begin
      next_s.act_chan = next_s.chan;
      next_s.act_ref = next_s.refsel;
      next_s.act_gain = next_s.gain;
    end
    // flag: set wins over clear
    if (clr_flag) begin
      next_s.flag = 1'b0;
    end
    if (done) begin
      next_s.flag = 1'b1;
    end
    if (!next_s.enable) begin
      next_s.state = adc_pkg::ST_IDLE;
      next_s.cnt = '0;
      next_s.first_done = 1'b0;
      next_s.core_start = 1'b0;
    end
    next_s.irq = next_s.flag && next_s.irq_en;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign core_enable = s.enable;
  assign core_clk_tick = tick;
  assign core_start = s.core_start;
  assign reference_select = s.act_ref;
  assign mux_positive = s.act_chan[3:0];
  assign mux_negative = {s.act_chan[adc_pkg::CH_SECTION], adc_pkg::COMMON_NEG};
  assign amp_enable = s.act_chan[adc_pkg::CH_DIFF];
  assign amp_gain = s.act_gain;
  assign conversion_irq = s.irq;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_flag_on_done;
    done && s.enable |=> s.flag;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set");
  property p_locked_discard;
    done && s.locked |=> $stable(s.result);
  endproperty
  a_locked_discard: assert property (p_locked_discard) else $error("locked result changed");
  property p_unlocked_write;
    done && !s.locked && s.enable |=> s.result == $past(core_result);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("result not written");
  property p_single_end;
    done && !free_run && s.enable |=> s.state == adc_pkg::ST_IDLE;
  endproperty
  a_single_end: assert property (p_single_end) else $error("start bit not cleared");
  property p_free_run;
    done && free_run && s.enable |=> s.state == adc_pkg::ST_CONV && s.core_start;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run stopped");
  property p_chan_lock;
    s.state == adc_pkg::ST_CONV ##1 s.state == adc_pkg::ST_CONV && !$past(done)
      |-> $stable(s.act_chan);
  endproperty
  a_chan_lock: assert property (p_chan_lock) else $error("channel changed mid conversion");
  property p_gate;
    !s.enable ##1 !s.enable |-> $stable(s.act_chan) && $stable(s.act_ref);
  endproperty
  a_gate: assert property (p_gate) else $error("selection applied while disabled");
  property p_trig_ignored;
    rise && s.state == adc_pkg::ST_CONV && !done |=> s.state == adc_pkg::ST_CONV;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("busy trigger acted");
  property p_first_len;
    done |-> s.cnt == (s.first_done ? adc_pkg::NORM_CONV : adc_pkg::FIRST_CONV) - 5'h01;
  endproperty
  a_first_len: assert property (p_first_len) else $error("conversion length wrong");
  property p_trig_start;
    trig_start |=> s.state == adc_pkg::ST_WAIT;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
endmodule

// ---- inc/adc_pkg.sv ----
package adc_pkg;
  localparam int RES_W = 10;
  localparam int TSEL_W = 3;
  localparam int TRIG_N = 8;
  localparam int PRESCALE_DIV = 2;
  localparam int HTRANS_ACTIVE = 1;
  // ---------------------------------------------
  // register map
  // ---------------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_CHAN_REF = 8'h08;
  localparam logic [7:0] OFF_RES_LOW = 8'h0C;
  localparam logic [7:0] OFF_RES_HIGH = 8'h10;
  // control/status a
  localparam int CA_ENABLE = 0;
  localparam int CA_START = 1;
  localparam int CA_AUTO = 2;
  localparam int CA_FLAG = 3;
  localparam int CA_IRQ_EN = 4;
  // channel/reference select
  localparam int CR_CHAN_LSB = 0;
  localparam int CR_REF_LSB = 6;
  localparam int CR_LADJ = 8;
  localparam int CR_GAIN_LSB = 9;
  localparam int CH_DIFF = 5;
  localparam int CH_SECTION = 3;
  localparam logic [2:0] COMMON_NEG = 3'h1;
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X10 = 2'h1;
  localparam logic [1:0] GAIN_X200 = 2'h2;
  // trigger select value that means free running
  localparam logic [TSEL_W-1:0] TSEL_FREE = 3'h0;
  // ---------------------------------------------
  // conversion timing in converter clocks
  // ---------------------------------------------
  localparam logic [4:0] NORM_CONV = 5'h0D;
  localparam logic [4:0] FIRST_CONV = 5'h19;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} conv_state_e;
endpackage

// ---- rtl/conv_prescaler.sv ----
module conv_prescaler #(
  parameter int DIVIDE = adc_pkg::PRESCALE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic enable,
  input wire logic restart,
  // converter clock pulse
  output logic tick
);
  localparam int W = $clog2(DIVIDE) + 1;
  localparam logic [W-1:0] LAST = W'(DIVIDE - 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } presc_s;
  presc_s s, next_s;
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!enable || restart) begin
      next_s.cnt = '0;
    end else if (s.cnt == LAST) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick = s.tick;
  property p_held;
    @(posedge clk) disable iff (!rstn) !enable |=> (s.cnt == '0) && !tick;
  endproperty
  a_held: assert property (p_held) else $error("prescaler ran while disabled");
  property p_restart;
    @(posedge clk) disable iff (!rstn) enable && restart |=> s.cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not honoured");
endmodule

// ---- rtl/trigger_edge.sv ----
module trigger_edge #(
  parameter int N = adc_pkg::TRIG_N,
  parameter int SEL_W = adc_pkg::TSEL_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // trigger sources
  input wire logic [N-1:0] sources,
  input wire logic [SEL_W-1:0] select,
  // rising edge pulse
  output logic rise
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } edge_s;
  edge_s s, next_s;
  always_comb begin
    next_s = s;
    next_s.meta = sources[select];
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign rise = s.sync & ~s.prev;
  property p_single;
    @(posedge clk) disable iff (!rstn) rise |=> !rise;
  endproperty
  a_single: assert property (p_single) else $error("held trigger gave two edges");
endmodule

// ---- verif/sar_adc_conversion_control_tb_top.sv ----
module sar_adc_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic clk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] trigger_in;
  logic [9:0] core_result;
  logic core_enable;
  logic core_clk_tick;
  logic core_start;
  logic [1:0] reference_select;
  logic [3:0] mux_positive;
  logic [3:0] mux_negative;
  logic amp_enable;
  logic [1:0] amp_gain;
  logic conversion_irq;
  int err_count;
  int n_tests;
  int n_start;
  int n0;
  int k;
  logic [31:0] seed;
  logic [31:0] q;
  logic [9:0] last_res;
  logic lad;

  assign hready = hreadyout;

  sar_adc_ctrl #(.DIVIDE(2)) dut_u (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_in(trigger_in),
    .core_result(core_result), .core_enable(core_enable), .core_clk_tick(core_clk_tick),
    .core_start(core_start), .reference_select(reference_select),
    .mux_positive(mux_positive), .mux_negative(mux_negative), .amp_enable(amp_enable),
    .amp_gain(amp_gain), .conversion_irq(conversion_irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) n_start <= 0;
    else if (core_start === 1'b1) n_start <= n_start + 1;
  end
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function logic [31:0] lfsr(logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function logic [31:0] exp_byte(logic [9:0] r, logic l, logic hi);
    if (l) exp_byte = hi ? {24'h000000, r[9:2]} : {24'h000000, r[1:0], 6'h00};
    else exp_byte = hi ? {30'h00000000, r[9:8]} : {24'h000000, r[7:0]};
  endfunction

  task test_done;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task wait_idle;
    for (int i = 0; i < 100; i++) begin
      ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h00000000);
      if (q[1] === 1'b0) break;
    end
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    err_count = 0;
    n_tests = 0;
    seed = 32'hA3D8EB80;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    trigger_in = 8'h00;
    core_result = 10'h000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h0);
    chk(q, 32'h00000000, "control reset");
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h00000000, "unmapped read");
    chk(hresp, 32'h00000000, "response");
    $display("test reset done");
    ahb(1'b1, adc_pkg::OFF_CHAN_REF, 32'h00000085);
    @(posedge clk);
    chk(mux_positive, 32'h00000000, "mux before enable");
    chk(reference_select, 32'h00000000, "reference before enable");
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000001);
    repeat (2) @(posedge clk);
    chk(mux_positive, 32'h00000005, "mux after enable");
    chk(reference_select, 32'h00000002, "reference after enable");
    $display("test enable done");
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      lad = k[0];
      last_res = (k == 0) ? 10'h3FF : seed[9:0];
      core_result <= last_res;
      ahb(1'b1, adc_pkg::OFF_CHAN_REF, {23'h000000, lad, 8'h05});
      ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000013);
      ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h0);
      chk(q[1], 32'h00000001, "start reads one");
      wait_idle;
      chk(q[3], 32'h00000001, "flag after single");
      chk(conversion_irq, 32'h00000001, "irq raised");
      ahb(1'b0, adc_pkg::OFF_RES_LOW, 32'h0);
      chk(q, exp_byte(last_res, lad, 1'b0), "low byte");
      ahb(1'b0, adc_pkg::OFF_RES_HIGH, 32'h0);
      chk(q, exp_byte(last_res, lad, 1'b1), "high byte");
      ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000019);
      repeat (2) @(posedge clk);
      chk(conversion_irq, 32'h00000000, "irq cleared");
    end
    $display("test single done");
    ahb(1'b0, adc_pkg::OFF_RES_LOW, 32'h0);
    core_result <= ~last_res;
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000003);
    wait_idle;
    chk(q[3], 32'h00000001, "flag while locked");
    ahb(1'b0, adc_pkg::OFF_RES_HIGH, 32'h0);
    chk(q, exp_byte(last_res, lad, 1'b1), "discarded result");
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h0000000B);
    wait_idle;
    ahb(1'b0, adc_pkg::OFF_RES_LOW, 32'h0);
    chk(q, exp_byte(~last_res, lad, 1'b0), "update after unlock");
    ahb(1'b0, adc_pkg::OFF_RES_HIGH, 32'h0);
    chk(q, exp_byte(~last_res, lad, 1'b1), "high after unlock");
    $display("test lock done");
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000003);
    // selection tracks software until the first converter tick starts the conversion
    repeat (2 * adc_pkg::PRESCALE_DIV) @(posedge clk);
    ahb(1'b1, adc_pkg::OFF_CHAN_REF, 32'h00000006);
    @(posedge clk);
    chk(mux_positive, 32'h00000005, "channel held");
    wait_idle;
    @(posedge clk);
    chk(mux_positive, 32'h00000006, "channel applied");
    $display("test channel done");
    ahb(1'b1, adc_pkg::OFF_CTRL_B, 32'h00000001);
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h0000000D);
    n0 = n_start;
    trigger_in <= 8'h02;
    repeat (8) @(posedge clk);
    ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h0);
    chk(q[1], 32'h00000001, "trigger start");
    trigger_in <= 8'h00;
    @(posedge clk);
    trigger_in <= 8'h02;
    wait_idle;
    repeat (40) @(posedge clk);
    chk(n_start - n0, 32'h00000001, "one triggered conversion");
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000007);
    ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h0);
    chk(q[1], 32'h00000001, "software start in auto");
    wait_idle;
    chk(n_start - n0, 32'h00000002, "held trigger idle");
    trigger_in <= 8'h00;
    $display("test trigger done");
    ahb(1'b1, adc_pkg::OFF_CTRL_B, 32'h00000000);
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h0000000D);
    n0 = n_start;
    repeat (100) @(posedge clk);
    chk(n_start - n0, 32'h00000000, "free run waits");
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000007);
    repeat (80) @(posedge clk);
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h0000000D);
    repeat (120) @(posedge clk);
    chk(n_start - n0 > 5, 32'h00000001, "free running");
    ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h0);
    chk(q[1], 32'h00000001, "busy in free run");
    chk(conversion_irq, 32'h00000000, "flag without irq");
    ahb(1'b1, adc_pkg::OFF_CTRL_A, 32'h00000000);
    ahb(1'b0, adc_pkg::OFF_CTRL_A, 32'h0);
    chk(q[1], 32'h00000000, "disable stops");
    $display("test free run done");
    test_done;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end
endmodule
